// file: nested_priority_interrupt_ctrl.sv
// Nested interrupt controller: arbitration, entry sequencing and APB registers.
// Assumes the core sequencer acknowledges stacking and vector fetch by pulses.
`timescale 1ns/1ps
module nested_priority_interrupt_ctrl (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic top_level_pin_irq_i,
  input wire logic [15:0] ext_pins_i,
  input wire logic [13:0] periph_flag_i,
  input wire logic [13:0] periph_en_i,
  input wire logic [13:0] flag_clear_i,
  input wire logic instr_done_i,
  input wire logic trap_i,
  input wire logic return_from_handler_instr_i,
  input wire logic [1:0] restore_level_i,
  input wire logic level_wr_i,
  input wire logic [1:0] level_wr_data_i,
  input wire logic stack_done_i,
  input wire logic fetch_done_i,
  input wire logic wait_i,
  input wire logic halt_i,
  output logic stack_push_o,
  output logic vector_load_o,
  output logic [15:0] vector_addr_o,
  output logic level_bit_high_o,
  output logic level_bit_low_o,
  output logic wake_o
);
  typedef enum logic [2:0] {ST_RESET_FETCH, ST_IDLE, ST_STACK, ST_LEVEL, ST_FETCH} seq_state_e;

  seq_state_e state_q, state_d;
  logic [1:0] level_q, level_d;
  logic [3:0] depth_q, depth_d;
  logic [3:0] sel_q, sel_d;
  logic [15:0] vaddr_q, vaddr_d;
  logic push_q, load_q, wake_q;
  logic halt_exit_q, halt_exit_d;
  logic [nested_irq_pkg::NUM_VEC-1:0] pend_q, pend_d;
  logic trap_pend_q, trap_pend_d;
  logic [nested_irq_pkg::NUM_GRP:0] line_q;
  logic [1:0] prio_q [0:15];
  logic [1:0] prio_d [0:15];
  logic [4:0] sense_q, sense_d;
  logic nested_q, nested_d;
  logic [31:0] rdata_q, rdata_d;
  logic pready_q, perr_q, perr_d;

  // Pin lines: four-pin groups ORed onto one line each, plus the top-level pin
  logic [nested_irq_pkg::NUM_GRP:0] line_now, line_edge;
  always_comb begin
    line_now[0] = top_level_pin_irq_i;
    for (int g = 0; g < nested_irq_pkg::NUM_GRP; g++) begin
      line_now[g+1] = |ext_pins_i[g*nested_irq_pkg::GRP_PINS +: nested_irq_pkg::GRP_PINS];
    end
    for (int g = 0; g <= nested_irq_pkg::NUM_GRP; g++) begin
      line_edge[g] = sense_q[g] ? (line_now[g] & ~line_q[g]) : (~line_now[g] & line_q[g]);
    end
  end

  // Arbitration
  logic [2:0] cur_rank, best_rank;
  logic [3:0] win_id;
  logic win_valid;
  logic [nested_irq_pkg::NUM_VEC-1:0] eligible;
  always_comb begin
    cur_rank = nested_pkg_rank(level_q);
    // Concurrent mode: a running handler is never preempted by a maskable one
    if (!nested_q && depth_q != 4'h0) begin
      cur_rank = nested_irq_pkg::lvl_rank(nested_irq_pkg::LVL3);
    end
    best_rank = 3'h0;
    win_id = 4'h0;
    win_valid = 1'b0;
    eligible = '0;
    for (int i = nested_irq_pkg::NUM_VEC - 1; i >= 1; i--) begin
      eligible[i] = pend_q[i] && (nested_irq_pkg::lvl_rank(prio_q[i]) > cur_rank)
                    && (!halt_exit_q || nested_irq_pkg::HALT_CAP[i]);
      // Lower index overwrites on a tie, so fixed order breaks ties
      if (eligible[i] && (!win_valid || nested_irq_pkg::lvl_rank(prio_q[i]) >= best_rank)) begin
        best_rank = nested_irq_pkg::lvl_rank(prio_q[i]);
        win_id = 4'(i);
        win_valid = 1'b1;
      end
    end
    if (pend_q[0]) begin
      win_id = nested_irq_pkg::ID_TLI;
      win_valid = 1'b1;
    end
    if (trap_pend_q) begin
      win_id = nested_irq_pkg::ID_TRAP;
      win_valid = 1'b1;
    end
  end

  function automatic logic [2:0] nested_pkg_rank(input logic [1:0] code);
    nested_pkg_rank = nested_irq_pkg::lvl_rank(code);
  endfunction : nested_pkg_rank

  logic take;
  assign take = (state_q == ST_IDLE) && instr_done_i && win_valid;

  // Pending latches
  logic [nested_irq_pkg::NUM_VEC-1:0] req_now;
  always_comb begin
    pend_d = pend_q;
    trap_pend_d = trap_pend_q;
    for (int i = 0; i < nested_irq_pkg::NUM_VEC; i++) begin
      req_now[i] = periph_flag_i[i] & periph_en_i[i];
    end
    pend_d[0] = pend_q[0] | line_edge[0];
    for (int i = 1; i < nested_irq_pkg::NUM_VEC; i++) begin
      if (nested_irq_pkg::EXT_MASK[i]) begin
        if (take && win_id == 4'(i)) begin
          pend_d[i] = 1'b0;
        end
        if (line_edge[i - nested_irq_pkg::EXT_FIRST + 1]) begin
          pend_d[i] = 1'b1;
        end
      end else begin
        if (req_now[i]) begin
          pend_d[i] = 1'b1;
        end
        // The clearing sequence wins: a waiting request is dropped
        if (flag_clear_i[i]) begin
          pend_d[i] = 1'b0;
        end
      end
    end
    if (take && win_id == nested_irq_pkg::ID_TLI) begin
      pend_d[0] = line_edge[0];
    end
    if (take && win_id == nested_irq_pkg::ID_TRAP) begin
      trap_pend_d = 1'b0;
    end
    if (trap_i) begin
      trap_pend_d = 1'b1;
    end
  end

  // Entry / return sequencer
  always_comb begin
    state_d = state_q;
    level_d = level_q;
    depth_d = depth_q;
    sel_d = sel_q;
    vaddr_d = vaddr_q;
    halt_exit_d = halt_exit_q;
    if (halt_i && wake_q && !halt_exit_q) begin
      halt_exit_d = 1'b1;
    end
    case (state_q)
      ST_RESET_FETCH: begin
        // No stacking after reset; runs at level 3
        level_d = nested_irq_pkg::LVL3;
        vaddr_d = nested_irq_pkg::VEC_RESET;
        sel_d = nested_irq_pkg::ID_RESET;
        if (fetch_done_i) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          sel_d = win_id;
          state_d = ST_STACK;
        end else if (return_from_handler_instr_i) begin
          level_d = restore_level_i;
          depth_d = depth_q - 4'h1;
        end else if (level_wr_i) begin
          level_d = level_wr_data_i;
        end
      end
      ST_STACK: begin
        if (stack_done_i) begin
          state_d = ST_LEVEL;
        end
      end
      ST_LEVEL: begin
        if (sel_q == nested_irq_pkg::ID_TRAP || sel_q == nested_irq_pkg::ID_TLI) begin
          level_d = nested_irq_pkg::LVL3;
        end else begin
          level_d = prio_q[sel_q];
        end
        if (sel_q == nested_irq_pkg::ID_TRAP) begin
          vaddr_d = nested_irq_pkg::VEC_TRAP;
        end else begin
          vaddr_d = nested_irq_pkg::VEC_FIRST - {11'h000, sel_q, 1'b0};
        end
        // Depth simply wraps: stack overflow goes unreported
        depth_d = depth_q + 4'h1;
        halt_exit_d = 1'b0;
        state_d = ST_FETCH;
      end
      ST_FETCH: begin
        if (fetch_done_i) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Wake: any pending wakes wait, halt needs a halt-capable source
  logic wake_d;
  always_comb begin
    wake_d = (wait_i && (|pend_q || trap_pend_q))
             || (halt_i && |(pend_q & nested_irq_pkg::HALT_CAP));
  end

  // APB register file
  logic acc_now;
  logic wr_now;
  logic [1:0] pidx;
  logic [7:0] wbyte, cur_byte;
  assign acc_now = psel_i && penable_i && !pready_q;
  // Writes land on the edge that completes the transfer, not one edge early
  assign wr_now = psel_i && penable_i && pready_q && pwrite_i;
  assign pidx = paddr_i[3:2];
  assign wbyte = pwdata_i[7:0];
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      prio_d[i] = prio_q[i];
    end
    sense_d = sense_q;
    nested_d = nested_q;
    rdata_d = 32'h0000_0000;
    perr_d = 1'b0;
    cur_byte = {prio_q[pidx*4+3], prio_q[pidx*4+2], prio_q[pidx*4+1], prio_q[pidx*4]};
    if (acc_now || wr_now) begin
      if (paddr_i <= nested_irq_pkg::OFS_PRIO3 && paddr_i[1:0] == 2'b00) begin
        rdata_d = {24'h000000, cur_byte};
        if (pidx == 2'h3) begin
          rdata_d[7:0] = cur_byte | nested_irq_pkg::PRIO3_RO_MASK;
        end
        if (wr_now) begin
          for (int f = 0; f < 4; f++) begin
            if (wbyte[2*f +: 2] != nested_irq_pkg::LVL0 && !(pidx == 2'h3 && f >= 2)) begin
              prio_d[pidx*4+f] = wbyte[2*f +: 2];
            end
          end
        end
      end else if (paddr_i == nested_irq_pkg::OFS_SENSE) begin
        rdata_d = {27'h0, sense_q};
        if (wr_now) begin
          sense_d = pwdata_i[4:0];
        end
      end else if (paddr_i == nested_irq_pkg::OFS_MODE) begin
        rdata_d = {31'h0, nested_q};
        if (wr_now) begin
          nested_d = pwdata_i[0];
        end
      end else if (paddr_i == nested_irq_pkg::OFS_STATUS) begin
        rdata_d = {21'h0, halt_exit_q, 1'b0, state_q, depth_q, level_q};
      end else if (paddr_i == nested_irq_pkg::OFS_PEND) begin
        rdata_d = {17'h0, trap_pend_q, pend_q};
      end else begin
        perr_d = 1'b1;
      end
    end
    // Answer only from the access cycle, so data and error stand one cycle
    if (!acc_now) begin
      rdata_d = 32'h0000_0000;
      perr_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= ST_RESET_FETCH;
      level_q <= nested_irq_pkg::LVL3;
      depth_q <= 4'h0;
      sel_q <= nested_irq_pkg::ID_RESET;
      vaddr_q <= nested_irq_pkg::VEC_RESET;
      push_q <= 1'b0;
      load_q <= 1'b0;
      wake_q <= 1'b0;
      halt_exit_q <= 1'b0;
      pend_q <= '0;
      trap_pend_q <= 1'b0;
      line_q <= '0;
      for (int i = 0; i < 16; i++) begin
        prio_q[i] <= nested_irq_pkg::LVL3;
      end
      sense_q <= nested_irq_pkg::SENSE_RST;
      nested_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      level_q <= level_d;
      depth_q <= depth_d;
      sel_q <= sel_d;
      vaddr_q <= vaddr_d;
      push_q <= (state_d == ST_STACK);
      load_q <= (state_d == ST_FETCH) || (state_d == ST_RESET_FETCH);
      wake_q <= wake_d;
      halt_exit_q <= halt_exit_d;
      pend_q <= pend_d;
      trap_pend_q <= trap_pend_d;
      line_q <= line_now;
      for (int i = 0; i < 16; i++) begin
        prio_q[i] <= prio_d[i];
      end
      sense_q <= sense_d;
      nested_q <= nested_d;
      rdata_q <= rdata_d;
      pready_q <= acc_now;
      perr_q <= perr_d;
    end
  end

  assign prdata_o = rdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = perr_q;
  assign stack_push_o = push_q;
  assign vector_load_o = load_q;
  assign vector_addr_o = vaddr_q;
  assign level_bit_high_o = level_q[1];
  assign level_bit_low_o = level_q[0];
  assign wake_o = wake_q;

  // Checks
  property p_nmi_level;
    @(posedge core_clk_i) disable iff (srst_i)
      (state_q == ST_LEVEL && (sel_q == nested_irq_pkg::ID_TRAP || sel_q == 4'h0))
      |=> level_q == nested_irq_pkg::LVL3;
  endproperty
  a_nmi_level: assert property (p_nmi_level) else $error("nmi entry level not 3");

  property p_mask_level;
    @(posedge core_clk_i) disable iff (srst_i)
      (state_q == ST_LEVEL && sel_q != nested_irq_pkg::ID_TRAP && sel_q != 4'h0)
      |=> level_q == $past(prio_q[sel_q]);
  endproperty
  a_mask_level: assert property (p_mask_level) else $error("entry level not from field");

  property p_take_boundary;
    @(posedge core_clk_i) disable iff (srst_i)
      $rose(push_q) |-> ($past(instr_done_i) && $past(state_q == ST_IDLE));
  endproperty
  a_take_boundary: assert property (p_take_boundary) else $error("entry mid instruction");

  property p_stack_then_fetch;
    @(posedge core_clk_i) disable iff (srst_i)
      (push_q && stack_done_i) |=> ##1 (load_q && !push_q);
  endproperty
  a_stack_then_fetch: assert property (p_stack_then_fetch) else $error("no fetch after stack");

  property p_vec_range;
    @(posedge core_clk_i) disable iff (srst_i)
      load_q |-> (vector_addr_o >= nested_irq_pkg::VEC_LAST && vector_addr_o[0] == 1'b0);
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector outside top area");

  property p_return_level;
    @(posedge core_clk_i) disable iff (srst_i)
      (state_q == ST_IDLE && !take && return_from_handler_instr_i)
      |=> level_q == $past(restore_level_i);
  endproperty
  a_return_level: assert property (p_return_level) else $error("return level not restored");

  property p_no_lvl0_write;
    @(posedge core_clk_i) disable iff (srst_i)
      (wr_now && paddr_i == nested_irq_pkg::OFS_PRIO0
       && pwdata_i[5:4] == nested_irq_pkg::LVL0) |=> $stable(prio_q[2]);
  endproperty
  a_no_lvl0_write: assert property (p_no_lvl0_write) else $error("level 0 code stored");

  property p_clear_drops;
    @(posedge core_clk_i) disable iff (srst_i)
      (flag_clear_i[9]) |=> !pend_q[9];
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("clear kept pending");

  property p_halt_wake;
    @(posedge core_clk_i) disable iff (srst_i)
      (halt_i && !wait_i && (pend_q & nested_irq_pkg::HALT_CAP) == '0) |=> !wake_o;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt woken by wrong source");

  property p_edge_latch;
    @(posedge core_clk_i) disable iff (srst_i)
      (line_edge[1] && !(take && win_id == 4'h2)) |=> pend_q[2];
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");
endmodule : nested_priority_interrupt_ctrl

// file: nested_irq_pkg.sv
// Constants, encodings and helpers for the nested priority interrupt controller.
// Assumes one core clock and an APB master that reaches the register words.
// Behaviour
// - Four software nesting levels, sixteen fixed vectors, three non-maskable sources.
// - Vector addresses sit from ffe0 to ffff in hardware priority order.
// - Current level is held in condition-code bits 5 and 3.
// - Level codes: 0=10, 1=01, 2=00, 3=11 (disabled).
// - Servicing waits until the current instruction has finished.
// - Entry pushes program counter, index, accumulator and condition code.
// - Maskable entry loads the level from that vector's priority field.
// - After stacking and level load, fetch from the serviced vector address.
// - Return pops all saved state, restoring the previous level.
// - Highest software priority wins; ties go to the fixed hardware order.
// - Unserviced requests stay latched until they become highest pending.
// - Non-maskable sources rank above every software priority.
// - Non-maskable sources ignore level, stack except reset, force level 3, wake halt; only the pin wakes halt here, not a pending trap.
// - Top-level pin edge raises an interrupt serviced like a trap.
// - Trap instruction raises software non-maskable; pin interrupt may preempt it.
// - Reset is highest; first routine runs at level 3.
// - Maskable taken only if enabled and priority strictly above current level.
// - Edge requests latch, clear on entry; pins of one line are ORed.
// - Peripheral request is flag and enable; clearing sequence drops pending latch.
// - Any interrupt wakes wait; only halt-capable ones wake halt and go first.
// - Concurrent or nested modes; hardware order main, lines 4..0, pin highest.
// - No stack overflow detection for deep nesting.
// - Priority fields reset to ones; writing the level 0 code is ignored.
package nested_irq_pkg;
  localparam int NUM_VEC = 14;
  localparam int NUM_PRIO_REGS = 4;
  localparam int GRP_PINS = 4;
  localparam int NUM_GRP = 4;

  // Level codes
  localparam logic [1:0] LVL0 = 2'b10;
  localparam logic [1:0] LVL1 = 2'b01;
  localparam logic [1:0] LVL2 = 2'b00;
  localparam logic [1:0] LVL3 = 2'b11;
  localparam logic [2:0] RANK_NMI = 3'h4;

  // Source ids held in the entry selector
  localparam logic [3:0] ID_TLI = 4'h0;
  localparam logic [3:0] ID_TRAP = 4'he;
  localparam logic [3:0] ID_RESET = 4'hf;

  // Vector map
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_FIRST = 16'hfffa;
  localparam logic [15:0] VEC_LAST = 16'hffe0;

  // Vector classes
  localparam logic [NUM_VEC-1:0] EXT_MASK = 14'h003c;
  localparam logic [NUM_VEC-1:0] HALT_CAP = 14'h00ff;
  localparam int EXT_FIRST = 2;

  // APB byte offsets
  localparam logic [7:0] OFS_PRIO0 = 8'h00;
  localparam logic [7:0] OFS_PRIO3 = 8'h0c;
  localparam logic [7:0] OFS_SENSE = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PEND = 8'h1c;

  localparam logic [7:0] PRIO_RST = 8'hff;
  localparam logic [7:0] PRIO3_RO_MASK = 8'hf0;
  localparam logic [4:0] SENSE_RST = 5'h00;

  function automatic logic [2:0] lvl_rank(input logic [1:0] code);
    case (code)
      LVL0: lvl_rank = 3'h0;
      LVL1: lvl_rank = 3'h1;
      LVL2: lvl_rank = 3'h2;
      default: lvl_rank = 3'h3;
    endcase
  endfunction : lvl_rank
endpackage : nested_irq_pkg

// file: core_seq_model.sv
// Stand-in for the core sequencer: acknowledges stacking and vector fetch.
// Assumes both requests are levels held until their acknowledge pulse.
`timescale 1ns/1ps
module core_seq_model (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic stack_push_i,
  input wire logic vector_load_i,
  input wire logic [3:0] delay_i,
  output logic stack_done_o,
  output logic fetch_done_o
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic busy;
  logic fire;

  // Open request not yet acknowledged; delay_i gives slow answers
  always_comb begin
    busy = (stack_push_i && !stack_done_o) || (vector_load_i && !fetch_done_o);
    fire = busy && (cnt_q >= delay_i);
    cnt_d = (!busy || fire) ? 4'h0 : cnt_q + 4'h1;
  end

  // One pulse per request, so a held request is never counted twice
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q <= 4'h0;
      stack_done_o <= 1'b0;
      fetch_done_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      stack_done_o <= fire && stack_push_i;
      fetch_done_o <= fire && !stack_push_i;
    end
  end
endmodule : core_seq_model

// file: nested_priority_interrupt_ctrl_bench.sv
// Directed bench: APB setup of priorities, then entry, return and wake checks.
// Assumes core_seq_model answers the entry handshake; the bench plays software.
`timescale 1ns/1ps
module nested_priority_interrupt_ctrl_bench;
  localparam logic [1:0] L0 = nested_irq_pkg::LVL0;
  localparam logic [1:0] L1 = nested_irq_pkg::LVL1;
  localparam logic [1:0] L2 = nested_irq_pkg::LVL2;
  localparam logic [1:0] L3 = nested_irq_pkg::LVL3;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, push, vload, lh, ll, wake, sdone, fdone;
  logic top_level_pin_irq = 1'b0, idone = 1'b1, trap = 1'b0, ret = 1'b0, lwr = 1'b0;
  logic wt = 1'b0, halt = 1'b0;
  logic [1:0] lvd = 2'b00;
  logic [15:0] ext = 16'h0000, vaddr;
  logic [13:0] flag = 14'h0000, clrp = 14'h0000;
  logic [3:0] dly = 4'h0;
  int fails = 0;
  int cmp_count = 0;

  initial forever #2.5 clk = ~clk;

  nested_priority_interrupt_ctrl DUT (
    .core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .top_level_pin_irq_i(top_level_pin_irq),
    .ext_pins_i(ext), .periph_flag_i(flag), .periph_en_i(14'h3fff),
    .flag_clear_i(clrp), .instr_done_i(idone), .trap_i(trap),
    .return_from_handler_instr_i(ret), .restore_level_i(lvd), .level_wr_i(lwr),
    .level_wr_data_i(lvd), .stack_done_i(sdone), .fetch_done_i(fdone),
    .wait_i(wt), .halt_i(halt), .stack_push_o(push), .vector_load_o(vload),
    .vector_addr_o(vaddr), .level_bit_high_o(lh), .level_bit_low_o(ll),
    .wake_o(wake));

  core_seq_model seq (.core_clk_i(clk), .srst_i(srst), .stack_push_i(push),
    .vector_load_i(vload), .delay_i(dly), .stack_done_o(sdone), .fetch_done_o(fdone));

  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic give_up(input string what);
    fails++;
    $display("CHECK FAILED t=%0t no answer: %s", $time, what);
    report_and_stop();
  endtask : give_up

  // Request held until pready is sampled high; released only after that edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= a;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) give_up("apb");
    end while (pready !== 1'b1);
    check(prdata, exp, "read data");
    check({31'h0, pslverr}, {31'h0, exp_err}, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) give_up("apb");
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : wr

  // Waits for the vector fetch request, then for its completion
  task automatic entry(input logic [15:0] va, input logic [1:0] lv, input logic pushed);
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    while (vload !== 1'b1) begin
      @(posedge clk);
      if (push === 1'b1) seen = 1'b1;
      n++;
      if (n > 60) give_up("entry");
    end
    check({16'h0, vaddr}, {16'h0, va}, "vector");
    check({30'h0, lh, ll}, {30'h0, lv}, "level");
    check({31'h0, seen}, {31'h0, pushed}, "stacking");
    while (vload === 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 120) give_up("fetch");
    end
  endtask : entry

  // Watches stacking (which=0) or wake (which=1) over a fixed span
  task automatic watch(input int cyc, input logic which, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      if ((which ? wake : push) === 1'b1) seen = 1'b1;
    end
    check({31'h0, seen}, {31'h0, exp}, which ? "wake" : "entry");
  endtask : watch

  // Software level write (is_ret=0) or return with popped level (is_ret=1)
  task automatic lvl(input logic is_ret, input logic [1:0] c);
    @(posedge clk);
    ret <= is_ret;
    lwr <= !is_ret;
    lvd <= c;
    @(posedge clk);
    ret <= 1'b0;
    lwr <= 1'b0;
  endtask : lvl

  task automatic clr(input int v);
    @(posedge clk);
    flag[v] <= 1'b0;
    clrp[v] <= 1'b1;
    @(posedge clk);
    clrp[v] <= 1'b0;
  endtask : clr

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    entry(16'hfffe, L3, 1'b0);
    rd(nested_irq_pkg::OFS_PRIO0, 32'h0000_00ff, 1'b0);
    wr(nested_irq_pkg::OFS_PRIO0, 8'hcf);
    wr(nested_irq_pkg::OFS_PRIO0, 8'h64);
    rd(nested_irq_pkg::OFS_PRIO0, 32'h0000_0044, 1'b0);
    wr(nested_irq_pkg::OFS_PRIO3, 8'h00);
    rd(nested_irq_pkg::OFS_PRIO3, 32'h0000_00f0, 1'b0);
    rd(8'h3c, 32'h0, 1'b1);
    wr(8'h04, 8'h1f);
    wr(8'h08, 8'hc5);
    wr(nested_irq_pkg::OFS_SENSE, 8'h1f);
    $display("test registers done");
    idone <= 1'b0;
    lvl(1'b0, L0);
    flag <= 14'h00c0;
    watch(8, 1'b0, 1'b0);
    idone <= 1'b1;
    entry(16'hffec, L2, 1'b1);
    clr(7);
    watch(8, 1'b0, 1'b0);
    lvl(1'b1, L0);
    entry(16'hffee, L1, 1'b1);
    clr(6);
    lvl(1'b1, L0);
    dly <= 4'h3;
    flag <= 14'h0300;
    entry(16'hffea, L1, 1'b1);
    clr(8);
    lvl(1'b1, L0);
    entry(16'hffe8, L1, 1'b1);
    clr(9);
    lvl(1'b1, L0);
    dly <= 4'h0;
    lvl(1'b0, L3);
    flag <= 14'h0400;
    watch(8, 1'b0, 1'b0);
    clr(10);
    lvl(1'b0, L0);
    watch(8, 1'b0, 1'b0);
    $display("test arbitration done");
    lvl(1'b0, L3);
    top_level_pin_irq <= 1'b1;
    entry(16'hfffa, L3, 1'b1);
    lvl(1'b1, L3);
    trap <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    top_level_pin_irq <= 1'b0;
    entry(16'hfffc, L3, 1'b1);
    // No trap is issued inside the pin handler
    top_level_pin_irq <= 1'b1;
    entry(16'hfffa, L3, 1'b1);
    lvl(1'b1, L3);
    lvl(1'b1, L3);
    lvl(1'b0, L0);
    ext <= 16'h0004;
    entry(16'hfff6, L2, 1'b1);
    lvl(1'b1, L0);
    watch(8, 1'b0, 1'b0);
    ext <= 16'h0000;
    $display("test non-maskable and external done");
    wt <= 1'b1;
    idone <= 1'b0;
    flag <= 14'h0200;
    watch(10, 1'b1, 1'b1);
    wt <= 1'b0;
    idone <= 1'b1;
    entry(16'hffe8, L1, 1'b1);
    clr(9);
    lvl(1'b1, L0);
    wr(8'h08, 8'hc7);
    halt <= 1'b1;
    idone <= 1'b0;
    flag <= 14'h0100;
    watch(8, 1'b1, 1'b0);
    ext <= 16'h0001;
    watch(10, 1'b1, 1'b1);
    halt <= 1'b0;
    idone <= 1'b1;
    entry(16'hfff6, L2, 1'b1);
    entry(16'hffea, L3, 1'b1);
    clr(8);
    lvl(1'b1, L2);
    lvl(1'b1, L0);
    ext <= 16'h0000;
    wr(nested_irq_pkg::OFS_MODE, 8'h00);
    flag <= 14'h0200;
    entry(16'hffe8, L1, 1'b1);
    flag[8] <= 1'b1;
    watch(8, 1'b0, 1'b0);
    clr(9);
    lvl(1'b1, L0);
    entry(16'hffea, L3, 1'b1);
    clr(8);
    lvl(1'b1, L0);
    wr(nested_irq_pkg::OFS_SENSE, 8'h1d);
    ext <= 16'h0001;
    watch(8, 1'b0, 1'b0);
    ext <= 16'h0000;
    entry(16'hfff6, L2, 1'b1);
    lvl(1'b1, L0);
    $display("test low power and modes done");
    report_and_stop();
  end
endmodule : nested_priority_interrupt_ctrl_bench
